//--- hw/fault_status_register_group.sv
// fault and operational status register groups with command-style access
`timescale 1ns/1ps
module fault_status_register_group
	import fault_status_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	// command port: one request per strobe
	input wire logic cmd_write,
	input wire logic cmd_read,
	input wire logic [2:0] cmd_sel,
	input wire logic [31:0] cmd_wdata,
	output logic [31:0] cmd_rdata,
	output logic cmd_rvalid,
	// live fault sources
	input wire logic current_imbalance,
	input wire logic voltage_control_shutdown,
	input wire logic [15:0] output_freq_hz,
	input wire logic high_freq_model,
	input wire logic output_short,
	input wire logic peak_overcurrent,
	input wire logic single_phase_input,
	input wire logic [15:0] input_line_vac,
	input wire logic [15:0] output_power_va,
	input wire logic ambient_overtemp,
	input wire logic hardware_fault,
	input wire logic peak_wire_drop_overvolt,
	input wire logic wire_drop_overvolt,
	input wire logic peak_overvolt,
	input wire logic estop_shutdown,
	input wire logic power_switch_off,
	input wire logic parallel_slave_wait,
	input wire logic parallel_error,
	input wire logic fatal_system_error,
	input wire logic parallel_config_ack,
	input wire logic undervolt_fault,
	input wire logic panel_output_off,
	input wire logic overpower_fault,
	input wire logic rms_overvolt,
	input wire logic foldback_fault,
	input wire logic hardware_overtemp,
	input wire logic line_input_fault,
	// operational condition sources; the summary bit is inserted here
	input wire logic [31:0] oper_cond_in,
	output logic no_fault_summary
);

	// ----------------------------------------------------------------
	// constants sized for the measurement buses
	// ----------------------------------------------------------------
	localparam logic [15:0] UF_LIM = 16'(UNDERFREQ_LIMIT_HZ);
	localparam logic [15:0] OF_LIM_LO = 16'(OVERFREQ_LIMIT_LOW_MODEL_HZ);
	localparam logic [15:0] OF_LIM_HI = 16'(OVERFREQ_LIMIT_HIGH_MODEL_HZ);
	localparam logic [15:0] LINE_LIM = 16'(LOW_LINE_LIMIT_VAC);
	localparam logic [15:0] PWR_LIM = 16'(LOW_LINE_POWER_LIMIT_VA);

	logic [31:0] fault_cond_next;
	logic [31:0] fault_live_condition_reg;
	logic [31:0] fault_event_mask_reg;
	logic [31:0] operational_event_mask_reg;
	logic [31:0] oper_cond_reg;
	logic [31:0] fault_event_bits;
	logic [31:0] oper_event_bits;
	logic [31:0] rdata_next;
	logic fault_read_clear;
	logic oper_read_clear;
	logic no_fault_next;
	logic [15:0] of_limit;

	// ----------------------------------------------------------------
	// condition assembly
	// ----------------------------------------------------------------

	// overfrequency threshold follows the fitted model
	assign of_limit = high_freq_model ? OF_LIM_HI : OF_LIM_LO;

	// map each fault source to its bit; unused bits stay zero
	always_comb begin
		fault_cond_next = 32'h0000_0000;
		fault_cond_next[BIT_CURRENT_IMBALANCE] = current_imbalance;
		fault_cond_next[BIT_VOLTAGE_CONTROL_SHUTDOWN] = voltage_control_shutdown;
		fault_cond_next[BIT_UNDERFREQUENCY_FAULT] = output_freq_hz < UF_LIM;
		fault_cond_next[BIT_OVERFREQUENCY_FAULT] = output_freq_hz > of_limit;
		fault_cond_next[BIT_OUTPUT_SHORT] = output_short;
		fault_cond_next[BIT_PEAK_OVERCURRENT] = peak_overcurrent;
		fault_cond_next[BIT_LOW_LINE_OVERPOWER] = single_phase_input && (input_line_vac < LINE_LIM)
			&& (output_power_va > PWR_LIM);
		fault_cond_next[BIT_AMBIENT_OVERTEMP] = ambient_overtemp;
		fault_cond_next[BIT_HARDWARE_FAULT] = hardware_fault;
		fault_cond_next[BIT_PEAK_WIRE_DROP_OVERVOLT] = peak_wire_drop_overvolt;
		fault_cond_next[BIT_WIRE_DROP_OVERVOLT] = wire_drop_overvolt;
		fault_cond_next[BIT_PEAK_OVERVOLT] = peak_overvolt;
		fault_cond_next[BIT_ESTOP_SHUTDOWN] = estop_shutdown;
		fault_cond_next[BIT_POWER_SWITCH_OFF] = power_switch_off;
		fault_cond_next[BIT_PARALLEL_SLAVE_WAIT] = parallel_slave_wait;
		fault_cond_next[BIT_PARALLEL_ERROR] = parallel_error;
		fault_cond_next[BIT_FATAL_SYSTEM_ERROR] = fatal_system_error;
		fault_cond_next[BIT_PARALLEL_CONFIG_ACK] = parallel_config_ack;
		fault_cond_next[BIT_UNDERVOLT_FAULT] = undervolt_fault;
		fault_cond_next[BIT_PANEL_OUTPUT_OFF] = panel_output_off;
		fault_cond_next[BIT_OVERPOWER_FAULT] = overpower_fault;
		fault_cond_next[BIT_RMS_OVERVOLT] = rms_overvolt;
		fault_cond_next[BIT_FOLDBACK_FAULT] = foldback_fault;
		fault_cond_next[BIT_HARDWARE_OVERTEMP] = hardware_overtemp;
		fault_cond_next[BIT_LINE_INPUT_FAULT] = line_input_fault;
	end

	// registered live condition; one cycle of latency keeps comparators off the read path
	always_ff @(posedge clock) begin
		if (!rstn) begin
			fault_live_condition_reg <= EVENT_RESET;
		end else begin
			fault_live_condition_reg <= fault_cond_next & FAULT_USED_MASK;
		end
	end

	// summary: no enabled fault active
	assign no_fault_next = ~|(fault_live_condition_reg & fault_event_mask_reg);

	// operational condition with the summary bit substituted
	always_ff @(posedge clock) begin
		if (!rstn) begin
			oper_cond_reg <= EVENT_RESET;
			no_fault_summary <= 1'b0;
		end else begin
			oper_cond_reg <= oper_cond_in;
			oper_cond_reg[BIT_NO_FAULT_SUMMARY] <= no_fault_next;
			no_fault_summary <= no_fault_next;
		end
	end

	// ----------------------------------------------------------------
	// writable masks
	// ----------------------------------------------------------------

	// full 32-bit values are accepted unchanged
	always_ff @(posedge clock) begin
		if (!rstn) begin
			operational_event_mask_reg <= MASK_RESET;
			fault_event_mask_reg <= MASK_RESET;
		end else if (cmd_write) begin
			if (cmd_sel == SEL_OPER_MASK) begin
				operational_event_mask_reg <= cmd_wdata;
			end
			if (cmd_sel == SEL_FAULT_MASK) begin
				fault_event_mask_reg <= cmd_wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// event latches
	// ----------------------------------------------------------------
	assign fault_read_clear = cmd_read && (cmd_sel == SEL_FAULT_EVENT);
	assign oper_read_clear = cmd_read && (cmd_sel == SEL_OPER_EVENT);

	edge_event_latch fault_latch (
		.clock(clock),
		.rstn(rstn),
		.cond(fault_live_condition_reg),
		.mask(fault_event_mask_reg),
		.read_clear(fault_read_clear),
		.event_bits(fault_event_bits)
	);

	edge_event_latch oper_latch (
		.clock(clock),
		.rstn(rstn),
		.cond(oper_cond_reg),
		.mask(operational_event_mask_reg),
		.read_clear(oper_read_clear),
		.event_bits(oper_event_bits)
	);

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------

	// value captured before the clear takes effect; writes to read-only selects are ignored
	always_comb begin
		case (cmd_sel)
			SEL_OPER_MASK: rdata_next = operational_event_mask_reg;
			SEL_OPER_EVENT: rdata_next = oper_event_bits;
			SEL_OPER_COND: rdata_next = oper_cond_reg;
			SEL_FAULT_EVENT: rdata_next = fault_event_bits & FAULT_USED_MASK;
			SEL_FAULT_COND: rdata_next = fault_live_condition_reg;
			SEL_FAULT_MASK: rdata_next = fault_event_mask_reg;
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	// answer one cycle after the read strobe; data holds until the next read
	always_ff @(posedge clock) begin
		if (!rstn) begin
			cmd_rdata <= 32'h0000_0000;
			cmd_rvalid <= 1'b0;
		end else begin
			cmd_rvalid <= cmd_read;
			if (cmd_read) begin
				cmd_rdata <= rdata_next;
			end
		end
	end

endmodule : fault_status_register_group

//--- hw/fault_status_pkg.sv
// constants and register map of the fault and operational status groups
//
// Behaviour
// - operational event mask is writable, any 32-bit value, readable back by query.
// - fault event register is read-only, derived from condition gated by fault mask.
// - fault event bit sets only on a 0 to 1 edge of an enabled condition.
// - reading the fault event register returns its bits, then clears all but edges rising in that cycle.
// - fault condition register is read-only live status, same bit layout as events.
// - fault event mask is writable 32 bits, gates events, readable back by query.
// - bit 26 current imbalance, bit 25 voltage control shutdown.
// - bit 24 underfrequency, output frequency below 15 Hz.
// - bit 23 overfrequency, above 1400 Hz or 5200 Hz depending on model.
// - bit 22 output short, bit 21 peak overcurrent.
// - bit 20 low line overpower, line below 170 Vac with output above 1500; code sets it for single phase input only.
// - bits 19 ambient overtemp, 18 hardware, 17 peak and 16 rms wire drop.
// - bit 15 peak overvolt, 14 emergency stop, 12 power switch off.
// - bit 11 parallel slave wait, bit 10 parallel error.
// - bit 9 fatal system error, bit 8 parallel config acknowledge.
// - bit 7 undervolt, 6 front panel output off, 5 overpower.
// - bits 4 rms overvolt, 3 foldback, 2 hardware overtemp, 1 line input.
// - no fault summary high only when no enabled fault condition is active.
// - operational events latch enabled rising edges and clear when read.
package fault_status_pkg;

	// ----------------------------------------------------------------
	// register selects of the command port
	// ----------------------------------------------------------------
	localparam logic [2:0] SEL_OPER_MASK = 3'h0;
	localparam logic [2:0] SEL_OPER_EVENT = 3'h1;
	localparam logic [2:0] SEL_OPER_COND = 3'h2;
	localparam logic [2:0] SEL_FAULT_EVENT = 3'h3;
	localparam logic [2:0] SEL_FAULT_COND = 3'h4;
	localparam logic [2:0] SEL_FAULT_MASK = 3'h5;

	// ----------------------------------------------------------------
	// fault bit positions
	// ----------------------------------------------------------------
	localparam int BIT_CURRENT_IMBALANCE = 26;
	localparam int BIT_VOLTAGE_CONTROL_SHUTDOWN = 25;
	localparam int BIT_UNDERFREQUENCY_FAULT = 24;
	localparam int BIT_OVERFREQUENCY_FAULT = 23;
	localparam int BIT_OUTPUT_SHORT = 22;
	localparam int BIT_PEAK_OVERCURRENT = 21;
	localparam int BIT_LOW_LINE_OVERPOWER = 20;
	localparam int BIT_AMBIENT_OVERTEMP = 19;
	localparam int BIT_HARDWARE_FAULT = 18;
	localparam int BIT_PEAK_WIRE_DROP_OVERVOLT = 17;
	localparam int BIT_WIRE_DROP_OVERVOLT = 16;
	localparam int BIT_PEAK_OVERVOLT = 15;
	localparam int BIT_ESTOP_SHUTDOWN = 14;
	localparam int BIT_POWER_SWITCH_OFF = 12;
	localparam int BIT_PARALLEL_SLAVE_WAIT = 11;
	localparam int BIT_PARALLEL_ERROR = 10;
	localparam int BIT_FATAL_SYSTEM_ERROR = 9;
	localparam int BIT_PARALLEL_CONFIG_ACK = 8;
	localparam int BIT_UNDERVOLT_FAULT = 7;
	localparam int BIT_PANEL_OUTPUT_OFF = 6;
	localparam int BIT_OVERPOWER_FAULT = 5;
	localparam int BIT_RMS_OVERVOLT = 4;
	localparam int BIT_FOLDBACK_FAULT = 3;
	localparam int BIT_HARDWARE_OVERTEMP = 2;
	localparam int BIT_LINE_INPUT_FAULT = 1;
	// operational group summary bit
	localparam int BIT_NO_FAULT_SUMMARY = 2;

	// ----------------------------------------------------------------
	// masks and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] FAULT_USED_MASK = 32'h07FF_DFFE;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam logic [31:0] EVENT_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// fault thresholds, in their own units
	// ----------------------------------------------------------------
	localparam int UNDERFREQ_LIMIT_HZ = 15;
	localparam int OVERFREQ_LIMIT_LOW_MODEL_HZ = 1400;
	localparam int OVERFREQ_LIMIT_HIGH_MODEL_HZ = 5200;
	localparam int LOW_LINE_LIMIT_VAC = 170;
	localparam int LOW_LINE_POWER_LIMIT_VA = 1500;

endpackage : fault_status_pkg

//--- hw/edge_event_latch.sv
// one status group: rising-edge event latch with read-to-clear
`timescale 1ns/1ps
module edge_event_latch
	import fault_status_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic [31:0] cond,
	input wire logic [31:0] mask,
	input wire logic read_clear,
	output logic [31:0] event_bits
);

	logic [31:0] cond_prev_reg;
	logic [31:0] event_reg;
	logic [31:0] rise;

	// enabled bits that went 0 to 1 this cycle
	assign rise = cond & ~cond_prev_reg & mask;

	// previous condition, for edge detection
	always_ff @(posedge clock) begin
		if (!rstn) begin
			cond_prev_reg <= EVENT_RESET;
		end else begin
			cond_prev_reg <= cond;
		end
	end

	// sticky bits; a rise in the clearing cycle survives so no edge is lost
	always_ff @(posedge clock) begin
		if (!rstn) begin
			event_reg <= EVENT_RESET;
		end else if (read_clear) begin
			event_reg <= rise;
		end else begin
			event_reg <= event_reg | rise;
		end
	end

	assign event_bits = event_reg;

endmodule : edge_event_latch

//--- tb/fault_status_checker.sv
// assertion checker for the fault status register group
`timescale 1ns/1ps
module fault_status_checker
	import fault_status_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic cmd_write,
	input wire logic cmd_read,
	input wire logic [2:0] cmd_sel,
	input wire logic [31:0] cmd_wdata,
	input wire logic [31:0] cmd_rdata,
	input wire logic cmd_rvalid,
	input wire logic output_short,
	input wire logic no_fault_summary
);
	logic short_en_reg;
	// shadow of mask bit 22 only; other faults can just pull the summary lower
	always_ff @(posedge clock) begin
		if (!rstn) begin
			short_en_reg <= 1'b0;
		end else if (cmd_write && cmd_sel == SEL_FAULT_MASK) begin
			short_en_reg <= cmd_wdata[BIT_OUTPUT_SHORT];
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	// ----------------------------------------------------------------
	// write, gap, read of the same mask; zero_mask_wr is a zero fault mask write with no fault mask write in the next cycle
	// ----------------------------------------------------------------
	sequence fault_mask_wr;
		cmd_write && cmd_sel == SEL_FAULT_MASK ##1 !cmd_write ##1 cmd_read && !cmd_write && cmd_sel == SEL_FAULT_MASK;
	endsequence
	sequence oper_mask_wr;
		cmd_write && cmd_sel == SEL_OPER_MASK ##1 !cmd_write ##1 cmd_read && !cmd_write && cmd_sel == SEL_OPER_MASK;
	endsequence
	sequence zero_mask_wr;
		cmd_write && cmd_sel == SEL_FAULT_MASK && cmd_wdata == 32'h0000_0000 ##1 !(cmd_write && cmd_sel == SEL_FAULT_MASK);
	endsequence
	a_read_answer_late: assert property (cmd_read |=> cmd_rvalid) else $error("read not answered");
	a_answer_needs_read: assert property (cmd_rvalid |-> $past(cmd_read)) else $error("stray read answer");
	a_fault_mask_back: assert property (fault_mask_wr |=> cmd_rdata == $past(cmd_wdata, 3))
		else $error("fault mask");
	a_oper_mask_back: assert property (oper_mask_wr |=> cmd_rdata == $past(cmd_wdata, 3))
		else $error("oper mask");
	a_unused_bits_zero: assert property (cmd_read && (cmd_sel == SEL_FAULT_EVENT || cmd_sel == SEL_FAULT_COND)
		|=> (cmd_rdata & ~FAULT_USED_MASK) == 32'h0000_0000) else $error("unused bit set");
	a_cond_shows_short: assert property (output_short[*2] ##0 (cmd_read && cmd_sel == SEL_FAULT_COND)
		|=> cmd_rdata[BIT_OUTPUT_SHORT]) else $error("live short missing");
	a_summary_low: assert property ((short_en_reg && output_short)[*3] |-> !no_fault_summary)
		else $error("summary high with fault");
	a_summary_high: assert property (zero_mask_wr |=> no_fault_summary) else $error("summary low, mask zero");
endmodule : fault_status_checker

bind fault_status_register_group fault_status_checker u_checker (.clock(clock), .rstn(rstn), .cmd_write(cmd_write),
	.cmd_read(cmd_read), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
	.output_short(output_short), .no_fault_summary(no_fault_summary));

//--- tb/fault_status_host.sv
// host model issuing register commands to the status groups
`timescale 1ns/1ps
module fault_status_host
	import fault_status_pkg::*;
(
	input wire logic clock,
	output logic cmd_write,
	output logic cmd_read,
	output logic [2:0] cmd_sel,
	output logic [31:0] cmd_wdata,
	input wire logic [31:0] cmd_rdata,
	input wire logic cmd_rvalid
);
	// idle command port from time zero
	initial begin
		cmd_write = 1'b0;
		cmd_read = 1'b0;
		cmd_sel = SEL_OPER_MASK;
		cmd_wdata = 32'h0000_0000;
	end
	// called at a falling edge; data is scrambled after the take so stale values never pass
	task write_reg(input logic [2:0] sel, input logic [31:0] data);
		cmd_write = 1'b1;
		cmd_sel = sel;
		cmd_wdata = data;
		@(negedge clock);
		cmd_write = 1'b0;
		cmd_wdata = ~data;
		@(negedge clock);
	endtask : write_reg
	// answer must stand at the falling edge half a cycle after the take, else unknown is returned
	task read_reg(input logic [2:0] sel, output logic [31:0] data);
		cmd_read = 1'b1;
		cmd_sel = sel;
		@(negedge clock);
		data = (cmd_rvalid === 1'b1) ? cmd_rdata : 32'hxxxx_xxxx;
		cmd_read = 1'b0;
		@(negedge clock);
	endtask : read_reg
endmodule : fault_status_host

//--- tb/fault_status_register_group_bench.sv
// self-checking bench for the fault status register group
`timescale 1ns/1ps
module fault_status_register_group_bench
	import fault_status_pkg::*;
;
	logic clock, rstn, cmd_write, cmd_read, cmd_rvalid, model, single, no_fault_summary;
	logic [2:0] cmd_sel;
	logic [31:0] cmd_wdata, cmd_rdata, fault_vec, oper_in, junk;
	logic [15:0] freq, vac, va;
	int mismatches, cmp_count;
	fault_status_host u_host (.clock(clock), .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_sel(cmd_sel),
		.cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid));
	fault_status_register_group u_dut (.clock(clock), .rstn(rstn), .cmd_write(cmd_write), .cmd_read(cmd_read),
		.cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
		.current_imbalance(fault_vec[26]), .voltage_control_shutdown(fault_vec[25]), .output_freq_hz(freq),
		.high_freq_model(model), .output_short(fault_vec[22]), .peak_overcurrent(fault_vec[21]),
		.single_phase_input(single), .input_line_vac(vac), .output_power_va(va), .ambient_overtemp(fault_vec[19]),
		.hardware_fault(fault_vec[18]), .peak_wire_drop_overvolt(fault_vec[17]), .wire_drop_overvolt(fault_vec[16]),
		.peak_overvolt(fault_vec[15]), .estop_shutdown(fault_vec[14]), .power_switch_off(fault_vec[12]),
		.parallel_slave_wait(fault_vec[11]), .parallel_error(fault_vec[10]), .fatal_system_error(fault_vec[9]),
		.parallel_config_ack(fault_vec[8]), .undervolt_fault(fault_vec[7]), .panel_output_off(fault_vec[6]),
		.overpower_fault(fault_vec[5]), .rms_overvolt(fault_vec[4]), .foldback_fault(fault_vec[3]),
		.hardware_overtemp(fault_vec[2]), .line_input_fault(fault_vec[1]), .oper_cond_in(oper_in),
		.no_fault_summary(no_fault_summary));
	// free-running 125 MHz clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// ----------------------------------------------------------------
	// shared helpers
	// ----------------------------------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task rd(input logic [2:0] sel, input logic [31:0] exp);
		logic [31:0] d;
		u_host.read_reg(sel, d);
		check(d, exp);
	endtask : rd
	// input to condition one edge, to event two edges
	task settle;
		repeat (2) @(negedge clock);
	endtask : settle
	task ana(input logic [15:0] f, input logic m, input logic s, input logic [15:0] v, input logic [15:0] p,
		input logic [31:0] exp);
		freq = f;
		model = m;
		single = s;
		vac = v;
		va = p;
		settle;
		rd(SEL_FAULT_COND, exp);
	endtask : ana
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task test_reset;
		rd(SEL_OPER_MASK, 32'h0000_0000);
		rd(SEL_FAULT_MASK, 32'h0000_0000);
		rd(SEL_FAULT_EVENT, 32'h0000_0000);
		rd(SEL_FAULT_COND, 32'h0000_0000);
		check({31'h0000_0000, no_fault_summary}, 32'h0000_0001);
	endtask : test_reset
	task test_masks;
		u_host.write_reg(SEL_OPER_MASK, 32'hA5A5_5A5A);
		rd(SEL_OPER_MASK, 32'hA5A5_5A5A);
		u_host.write_reg(SEL_FAULT_MASK, 32'hFFFF_FFFF);
		rd(SEL_FAULT_MASK, 32'hFFFF_FFFF);
		u_host.write_reg(SEL_FAULT_COND, 32'hFFFF_FFFF);
		rd(SEL_FAULT_COND, 32'h0000_0000);
	endtask : test_masks
	// one fault at a time through condition, event and clear
	task test_bit_map;
		for (int i = 1; i < 27; i++) begin
			if (!(i inside {13, 20, 23, 24})) begin
				fault_vec = 32'h0000_0001 << i;
				settle;
				rd(SEL_FAULT_COND, 32'h0000_0001 << i);
				rd(SEL_FAULT_EVENT, 32'h0000_0001 << i);
				fault_vec = 32'h0000_0000;
				rd(SEL_FAULT_EVENT, 32'h0000_0000);
			end
		end
	endtask : test_bit_map
	task test_thresholds;
		ana(16'h000E, 1'b0, 1'b1, 16'h00E6, 16'h03E8, 32'h0100_0000);
		ana(16'h000F, 1'b0, 1'b1, 16'h00E6, 16'h03E8, 32'h0000_0000);
		ana(16'h0578, 1'b0, 1'b1, 16'h00E6, 16'h03E8, 32'h0000_0000);
		ana(16'h0579, 1'b0, 1'b1, 16'h00E6, 16'h03E8, 32'h0080_0000);
		ana(16'h1450, 1'b1, 1'b1, 16'h00E6, 16'h03E8, 32'h0000_0000);
		ana(16'h1451, 1'b1, 1'b1, 16'h00E6, 16'h03E8, 32'h0080_0000);
		ana(16'h0032, 1'b0, 1'b1, 16'h00A9, 16'h05DD, 32'h0010_0000);
		ana(16'h0032, 1'b0, 1'b1, 16'h00AA, 16'h05DD, 32'h0000_0000);
		ana(16'h0032, 1'b0, 1'b1, 16'h00A9, 16'h05DC, 32'h0000_0000);
		ana(16'h0032, 1'b0, 1'b0, 16'h00A9, 16'h05DD, 32'h0000_0000);
	endtask : test_thresholds
	// masking, hold-high, fall, and latch after the fault has gone
	task test_events;
		u_host.write_reg(SEL_FAULT_MASK, 32'h0040_0000);
		u_host.read_reg(SEL_FAULT_EVENT, junk);
		fault_vec = 32'h0060_0000;
		settle;
		rd(SEL_FAULT_EVENT, 32'h0040_0000);
		check({31'h0000_0000, no_fault_summary}, 32'h0000_0000);
		rd(SEL_FAULT_EVENT, 32'h0000_0000);
		fault_vec = 32'h0020_0000;
		settle;
		rd(SEL_FAULT_EVENT, 32'h0000_0000);
		check({31'h0000_0000, no_fault_summary}, 32'h0000_0001);
		fault_vec = 32'h0040_0000;
		settle;
		fault_vec = 32'h0000_0000;
		settle;
		u_host.write_reg(SEL_FAULT_EVENT, 32'h0000_0000);
		rd(SEL_FAULT_EVENT, 32'h0040_0000);
		fault_vec = 32'h0040_0000;
		u_host.write_reg(SEL_FAULT_MASK, 32'h0000_0000);
		settle;
		check({31'h0000_0000, no_fault_summary}, 32'h0000_0001);
		fault_vec = 32'h0000_0000;
	endtask : test_events
	task test_oper;
		u_host.write_reg(SEL_OPER_MASK, 32'hFFFF_FFFF);
		settle;
		u_host.read_reg(SEL_OPER_EVENT, junk);
		oper_in = 32'h0000_0020;
		settle;
		rd(SEL_OPER_COND, 32'h0000_0024);
		rd(SEL_OPER_EVENT, 32'h0000_0020);
		rd(SEL_OPER_EVENT, 32'h0000_0000);
	endtask : test_oper
	task stop_test;
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	// main sequence after a 20-cycle reset
	initial begin
		{mismatches, cmp_count} = '0;
		{rstn, fault_vec, oper_in, model, single} = '0;
		{freq, vac, va} = {16'h0032, 16'h00E6, 16'h03E8};
		repeat (20) @(negedge clock);
		rstn = 1'b1;
		settle;
		test_reset;
		test_masks;
		test_bit_map;
		test_thresholds;
		test_events;
		test_oper;
		stop_test;
	end
	// watchdog, about seventeen times the expected run length
	initial begin
		repeat (5000) @(posedge clock);
		mismatches++;
		stop_test;
	end
endmodule : fault_status_register_group_bench
